/* hw/watchdog_timeout_monitor.sv */
// Watchdog time-out monitor with its control and interrupt registers.
// Assumes a simple register port, synchronous single-clock inputs,
// and reset requests already aligned to core_clk_i.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module watchdog_timeout_monitor
    import wdt_pkg::*;
#(
    parameter int TOUT_CLKS_0 = 4096,
    parameter int TOUT_CLKS_1 = 65536,
    parameter int TOUT_CLKS_2 = 262144,
    parameter int TOUT_CLKS_3 = 1048576
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pwr_fail_rst_i,
    input wire logic ext_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic timed_access_ok_i,
    input wire logic global_irq_enable_i,
    input wire logic [7:0] config_byte_zero_i,
    input wire logic rc_tick_i,
    output logic [7:0] rdata_o,
    output logic wd_irq_o,
    output logic irq_o,
    output logic sys_rst_o
);

    logic wd_run_a;
    logic [1:0] interval_sel;
    logic timeout_flag;
    logic wd_reset_cause_flag;
    logic wd_reset_enable;
    logic wd_restart;
    logic [EV_W-1:0] irq_enable;
    logic [EV_W-1:0] irq_status;
    logic [DIV_W-1:0] div_cnt;
    logic [POST_W-1:0] post_cnt;
    logic pending;
    logic [3:0] pulse_cnt;
    logic power_rst;
    logic wd_clock_source_sel;
    logic tick;
    logic tout_hit;
    logic wd_fire;
    logic ctl_wr;
    logic prot_wr;
    logic restart_wr;
    logic clr_wr;

    function automatic logic [DIV_W-1:0] last_count(input logic [1:0] sel);
        logic [DIV_W-1:0] v;
        v = '0;
        unique case (sel)
            2'b00: v = DIV_W'(TOUT_CLKS_0 - 1);
            2'b01: v = DIV_W'(TOUT_CLKS_1 - 1);
            2'b10: v = DIV_W'(TOUT_CLKS_2 - 1);
            2'b11: v = DIV_W'(TOUT_CLKS_3 - 1);
        endcase
        return v;
    endfunction

    assign power_rst = rst_i | pwr_fail_rst_i;
    assign wd_clock_source_sel = config_byte_zero_i[BIT_CLK_SRC];
    // RC source advances on its tick, CPU clock on every edge
    assign tick = wd_clock_source_sel ? rc_tick_i : 1'b1;
    assign ctl_wr = wr_i && (addr_i == ADDR_WD_CONTROL);
    assign prot_wr = ctl_wr && timed_access_ok_i;
    assign restart_wr = prot_wr && wdata_i[BIT_RESTART];
    assign clr_wr = wr_i && (addr_i == ADDR_IRQ_CLEAR);
    assign tout_hit = wd_run_a && tick && !pending_blocked()
        && (div_cnt == last_count(interval_sel));
    // Window pauses while halted, so the reset waits for the run bit too
    assign wd_fire = pending && wd_reset_enable && wd_run_a && tick
        && (post_cnt == POST_LAST) && !restart_wr;

    function automatic logic pending_blocked();
        return restart_wr;
    endfunction

    // Divider chain
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            div_cnt <= '0;
        end
        else if (ext_rst_i || wd_fire || restart_wr)
        begin
            div_cnt <= '0;
        end
        else if (tout_hit)
        begin
            div_cnt <= '0;
        end
        else if (wd_run_a && tick)
        begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    // Post time-out window
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            pending <= 1'b0;
            post_cnt <= '0;
        end
        else if (ext_rst_i || wd_fire || restart_wr)
        begin
            pending <= 1'b0;
            post_cnt <= '0;
        end
        else if (tout_hit && !pending)
        begin
            pending <= 1'b1;
            post_cnt <= '0;
        end
        else if (pending && wd_run_a && tick)
        begin
            if (post_cnt == POST_LAST)
            begin
                pending <= 1'b0;
            end
            post_cnt <= post_cnt + POST_W'(1);
        end
    end

    // System reset pulse
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            sys_rst_o <= 1'b0;
            pulse_cnt <= '0;
        end
        else if (wd_fire)
        begin
            sys_rst_o <= 1'b1;
            pulse_cnt <= '0;
        end
        else if (sys_rst_o)
        begin
            pulse_cnt <= pulse_cnt + 4'h1;
            if (pulse_cnt == RST_PULSE_LAST)
            begin
                sys_rst_o <= 1'b0;
            end
        end
    end

    // Run bit and interval select
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            wd_run_a <= 1'b0;
            interval_sel <= SEL_RESET;
        end
        else if (prot_wr)
        begin
            wd_run_a <= wdata_i[BIT_RUN];
            interval_sel <= wdata_i[BIT_SEL_HI:BIT_SEL_LO];
        end
    end

    // Reset enable and restart strobe
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst || ext_rst_i || wd_fire)
        begin
            wd_reset_enable <= 1'b0;
            wd_restart <= 1'b0;
        end
        else
        begin
            if (prot_wr)
            begin
                wd_reset_enable <= wdata_i[BIT_RST_EN];
            end
            wd_restart <= restart_wr;
        end
    end

    // Time-out flag: set wins over a software clear
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst || ext_rst_i || wd_fire)
        begin
            timeout_flag <= 1'b0;
        end
        else if (tout_hit)
        begin
            timeout_flag <= 1'b1;
        end
        else if (prot_wr)
        begin
            timeout_flag <= wdata_i[BIT_TIMEOUT];
        end
    end

    // Reset cause flag
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            wd_reset_cause_flag <= 1'b0;
        end
        else if (wd_fire)
        begin
            wd_reset_cause_flag <= 1'b1;
        end
        else if (ctl_wr && !wdata_i[BIT_CAUSE])
        begin
            wd_reset_cause_flag <= 1'b0;
        end
    end

    // Sticky event status and enables
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            irq_status <= EV_RESET;
            irq_enable <= EV_RESET;
        end
        else
        begin
            irq_status[EV_TIMEOUT] <= tout_hit
                || (irq_status[EV_TIMEOUT] && !(clr_wr && wdata_i[EV_TIMEOUT]));
            irq_status[EV_WD_RESET] <= wd_fire
                || (irq_status[EV_WD_RESET] && !(clr_wr && wdata_i[EV_WD_RESET]));
            if (wr_i && (addr_i == ADDR_IRQ_ENABLE))
            begin
                irq_enable <= wdata_i[EV_W-1:0];
            end
        end
    end

    // Interrupt outputs, separate from the reset path
    always_ff @(posedge core_clk_i)
    begin
        if (power_rst)
        begin
            wd_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            wd_irq_o <= timeout_flag && irq_enable[EV_TIMEOUT]
                && global_irq_enable_i;
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= RDATA_RESET;
        end
        else if (rd_i)
        begin
            unique case (addr_i)
                ADDR_WD_CONTROL: rdata_o <= {wd_run_a, 1'b0, interval_sel,
                    timeout_flag, wd_reset_cause_flag, wd_reset_enable,
                    wd_restart};
                ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_status};
                ADDR_IRQ_ENABLE: rdata_o <= {6'h00, irq_enable};
                default: rdata_o <= RDATA_RESET;
            endcase
        end
        else
        begin
            rdata_o <= RDATA_RESET;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_irq_gating: assert property (
        wd_irq_o |-> $past(timeout_flag && irq_enable[EV_TIMEOUT]
            && global_irq_enable_i))
        else $error("watchdog irq without flag and enables");
    a_timeout_flag: assert property (
        (tout_hit && !pwr_fail_rst_i && !ext_rst_i && !wd_fire)
            |=> timeout_flag)
        else $error("time-out did not set flag");
    a_reset_width: assert property (
        $rose(sys_rst_o) |-> sys_rst_o[*8] ##1 !sys_rst_o)
        else $error("watchdog reset width wrong");
    a_reset_cause: assert property (
        $rose(sys_rst_o) |-> wd_reset_cause_flag)
        else $error("cause flag not set with reset");
    a_reset_needs_en: assert property (
        $rose(sys_rst_o) |-> $past(wd_reset_enable)
            && $past(post_cnt) == POST_LAST)
        else $error("reset without enable or early");
    a_restart_clear: assert property (
        wd_restart |-> div_cnt == '0 && !pending ##1 !wd_restart)
        else $error("restart did not clear count");
    a_halt_holds: assert property (
        (!wd_run_a && !restart_wr && !ext_rst_i && !pwr_fail_rst_i
            && !wd_fire) |=> $stable(div_cnt))
        else $error("divider moved while halted");
    a_power_stop: assert property (
        pwr_fail_rst_i |=> !wd_run_a && !wd_reset_cause_flag)
        else $error("power reset left watchdog running");
    a_rst_en_clear: assert property (
        (ext_rst_i || wd_fire) |=> !wd_reset_enable)
        else $error("reset enable survived a reset");
    a_run_kept: assert property (
        (wd_fire && !pwr_fail_rst_i && !prot_wr)
            |=> wd_run_a == $past(wd_run_a) && div_cnt == '0)
        else $error("watchdog reset changed run state");
    a_flag_sticky: assert property (
        (timeout_flag && !prot_wr && !ext_rst_i && !pwr_fail_rst_i && !wd_fire)
            |=> timeout_flag)
        else $error("time-out flag cleared by hardware");
    a_cause_hold: assert property (
        (wd_reset_cause_flag && !ctl_wr && !pwr_fail_rst_i) |=> wd_reset_cause_flag)
        else $error("cause flag lost without software clear");
    a_ext_keeps_cause: assert property (
        (ext_rst_i && !pwr_fail_rst_i && !ctl_wr && !wd_fire)
            |=> wd_reset_cause_flag == $past(wd_reset_cause_flag))
        else $error("external reset changed cause flag");
    a_no_fire_disabled: assert property (
        !wd_reset_enable |-> !wd_fire)
        else $error("watchdog reset while reset disabled");
    a_div_wraps: assert property (
        (tout_hit && !pwr_fail_rst_i) |=> div_cnt == '0)
        else $error("divider did not wrap at time-out");
    a_window_start: assert property (
        (tout_hit && !pending && !pwr_fail_rst_i && !ext_rst_i)
            |=> pending && post_cnt == '0)
        else $error("post time-out window did not open");

    c_timeout: cover property (tout_hit);
    c_wd_reset: cover property ($rose(sys_rst_o));
    c_restart_in_window: cover property (pending && restart_wr);
    c_irq: cover property ($rose(wd_irq_o));

endmodule

/* shared/wdt_pkg.sv */
// Constants for the watchdog time-out monitor.
// Shared by the design and its bench; no clocked logic here.
package wdt_pkg;
    localparam int DIV_W = 21;
    localparam int POST_W = 9;
    // Last window count; forced reset fires 512 ticks after the time-out
    localparam logic [POST_W-1:0] POST_LAST = 9'h1ff;
    // System reset width: two machine cycles of four clocks
    localparam int MACHINE_CYCLE_CLKS = 4;
    localparam int RST_PULSE_CLKS = 2 * MACHINE_CYCLE_CLKS;
    localparam logic [3:0] RST_PULSE_LAST = 4'(RST_PULSE_CLKS - 1);
    // Register byte addresses
    localparam logic [7:0] ADDR_WD_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
    // Control register bit positions
    localparam int BIT_RUN = 7;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_TIMEOUT = 3;
    localparam int BIT_CAUSE = 2;
    localparam int BIT_RST_EN = 1;
    localparam int BIT_RESTART = 0;
    // Clock source select inside the configuration byte
    localparam int BIT_CLK_SRC = 7;
    // Event bits of status, clear and enable registers
    localparam int EV_TIMEOUT = 0;
    localparam int EV_WD_RESET = 1;
    localparam int EV_W = 2;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage

/* test/tb_watchdog_timeout_monitor.sv */
// Self-checking bench for the watchdog time-out monitor.
// Drives the register port and reset inputs directly; short intervals via parameters.
`timescale 1ns/1ps
module tb_watchdog_timeout_monitor;
    import wdt_pkg::*;
    localparam int N0 = 16;
    logic core_clk_i = 0, rst_i = 1, pwr_fail_rst_i = 0, ext_rst_i = 0;
    logic wr_i = 0, rd_i = 0, timed_access_ok_i = 0, global_irq_enable_i = 0, rc_tick_i = 0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, config_byte_zero_i = 8'h00;
    logic [7:0] rdata_o;
    logic wd_irq_o, irq_o, sys_rst_o, rst_seen;
    int n_fail = 0, checks_done = 0;

    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (sys_rst_o === 1'b1) rst_seen <= 1'b1;

    watchdog_timeout_monitor #(.TOUT_CLKS_0(N0), .TOUT_CLKS_1(32), .TOUT_CLKS_2(64),
        .TOUT_CLKS_3(128)) watchdog_timeout_monitor_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pwr_fail_rst_i(pwr_fail_rst_i),
        .ext_rst_i(ext_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .timed_access_ok_i(timed_access_ok_i), .global_irq_enable_i(global_irq_enable_i),
        .config_byte_zero_i(config_byte_zero_i), .rc_tick_i(rc_tick_i), .rdata_o(rdata_o),
        .wd_irq_o(wd_irq_o), .irq_o(irq_o), .sys_rst_o(sys_rst_o));

    task automatic close_out;
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        timed_access_ok_i <= ta;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        timed_access_ok_i <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp,
        input logic [7:0] mask);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp & mask, rdata_o & mask);
    endtask

    task automatic pulse(input int k);
        @(posedge core_clk_i);
        rst_i <= (k == 0);
        pwr_fail_rst_i <= (k == 1);
        ext_rst_i <= (k == 2);
        @(posedge core_clk_i);
        {rst_i, pwr_fail_rst_i, ext_rst_i} <= 3'h0;
    endtask

    task automatic t_reset;
        rd_chk("control", ADDR_WD_CONTROL, 8'h00, 8'hff);
        wr(ADDR_WD_CONTROL, 8'h83, 1'b0);
        cyc(40);
        rd_chk("control", ADDR_WD_CONTROL, 8'h00, 8'hff);
        rd_chk("unmapped", 8'h10, 8'h00, 8'hff);
        rd_chk("clear reg", ADDR_IRQ_CLEAR, 8'h00, 8'hff);
        rd_chk("status", ADDR_IRQ_STATUS, 8'h00, 8'hff);
    endtask

    task automatic t_intervals;
        int n;
        for (int s = 0; s < 4; s++)
        begin
            n = N0 << s;
            wr(ADDR_WD_CONTROL, {2'b10, 2'(s), 4'h1}, 1'b1);
            cyc(n - 6);
            rd_chk("control", ADDR_WD_CONTROL, {2'b10, 2'(s), 4'h0}, 8'hff);
            cyc(6);
            rd_chk("control", ADDR_WD_CONTROL, {2'b10, 2'(s), 4'h8}, 8'hff);
            wr(ADDR_WD_CONTROL, {2'b10, 2'(s), 4'h0}, 1'b1);
            cyc(n + 4);
            rd_chk("flag", ADDR_WD_CONTROL, 8'h08, 8'h08);
        end
    endtask

    task automatic t_irq;
        wr(ADDR_IRQ_ENABLE, 8'h01, 1'b0);
        global_irq_enable_i <= 1'b1;
        wr(ADDR_WD_CONTROL, 8'h81, 1'b1);
        cyc(N0 + 6);
        chk("wd_irq_o", 8'h01, {7'h0, wd_irq_o});
        chk("irq_o", 8'h01, {7'h0, irq_o});
        chk("sys_rst_o", 8'h00, {7'h0, sys_rst_o});
        global_irq_enable_i <= 1'b0;
        cyc(3);
        chk("wd_irq_o", 8'h00, {7'h0, wd_irq_o});
        wr(ADDR_WD_CONTROL, 8'h08, 1'b1);
        wr(ADDR_IRQ_CLEAR, 8'h01, 1'b0);
        cyc(3);
        chk("irq_o", 8'h00, {7'h0, irq_o});
        cyc(40);
        rd_chk("control", ADDR_WD_CONTROL, 8'h08, 8'hff);
        wr(ADDR_WD_CONTROL, 8'h00, 1'b1);
        rd_chk("control", ADDR_WD_CONTROL, 8'h00, 8'hff);
        wr(ADDR_IRQ_ENABLE, 8'h00, 1'b0);
    endtask

    task automatic t_wdreset;
        int i;
        int w;
        wr(ADDR_WD_CONTROL, 8'h83, 1'b1);
        i = 0;
        while (sys_rst_o !== 1'b1 && i < N0 + 540)
        begin
            cyc(1);
            i++;
        end
        chk("reset delay ok", 8'h01, {7'h0, i >= N0 + 508 && i < N0 + 540});
        w = 0;
        while (sys_rst_o === 1'b1 && w < 20)
        begin
            cyc(1);
            w++;
        end
        chk("reset width", 8'(RST_PULSE_CLKS), 8'(w));
        rd_chk("control", ADDR_WD_CONTROL, 8'h84, 8'hf7);
        rd_chk("status", ADDR_IRQ_STATUS, 8'h02, 8'h02);
        chk("irq_o masked", 8'h00, {7'h0, irq_o});
        pulse(2);
        rd_chk("control", ADDR_WD_CONTROL, 8'h84, 8'h86);
        pulse(1);
        cyc(40);
        rd_chk("control", ADDR_WD_CONTROL, 8'h00, 8'hff);
        wr(ADDR_IRQ_CLEAR, 8'h03, 1'b0);
    endtask

    task automatic t_restart;
        rst_seen = 1'b0;
        wr(ADDR_WD_CONTROL, 8'h83, 1'b1);
        repeat (60)
        begin
            cyc(20);
            wr(ADDR_WD_CONTROL, 8'h83, 1'b1);
        end
        rd_chk("restart bit", ADDR_WD_CONTROL, 8'h00, 8'h01);
        chk("no reset", 8'h00, {7'h0, rst_seen});
        wr(ADDR_WD_CONTROL, 8'h81, 1'b1);
        cyc(N0 + 600);
        chk("no reset", 8'h00, {7'h0, rst_seen});
        rd_chk("flag", ADDR_WD_CONTROL, 8'h88, 8'h8e);
        wr(ADDR_WD_CONTROL, 8'h00, 1'b1);
    endtask

    task automatic t_rcsrc;
        config_byte_zero_i <= 8'h80;
        wr(ADDR_WD_CONTROL, 8'h81, 1'b1);
        cyc(60);
        rd_chk("flag", ADDR_WD_CONTROL, 8'h00, 8'h08);
        rc_tick_i <= 1'b1;
        cyc(N0 + 6);
        rd_chk("flag", ADDR_WD_CONTROL, 8'h08, 8'h08);
        rc_tick_i <= 1'b0;
        config_byte_zero_i <= 8'h00;
        wr(ADDR_WD_CONTROL, 8'h00, 1'b1);
    endtask

    initial
    begin
        cyc(10);
        rst_i <= 1'b0;
        t_reset();
        t_intervals();
        t_irq();
        t_wdreset();
        t_restart();
        t_rcsrc();
        close_out();
    end

    initial
    begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule
